//--- common/mac_map.svh
// Register map, field positions, reset values and timing counts of the
// multiply-accumulate unit. Included by the package, the checker and the bench.
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH

// ==========================================================
// Register byte addresses
`define MAC_OFS_OPA       16'h1BE0
`define MAC_OFS_OPB       16'h1BE4
`define MAC_OFS_ACCL      16'h1BE8
`define MAC_OFS_ACCH      16'h1BEC
`define MAC_OFS_CTRL      16'h1BFC

// ==========================================================
// Control register fields
`define MAC_CTL_OVF       7
`define MAC_CTL_SOFT      6
`define MAC_CTL_TRG_HI    5
`define MAC_CTL_TRG_LO    3
`define MAC_CTL_SIGN      2
`define MAC_CTL_MODE_HI   1
`define MAC_CTL_MODE_LO   0

// ==========================================================
// Reset values
`define MAC_RST_CTRL      8'h00
`define MAC_RST_DATA      32'h0000_0000

// ==========================================================
// Host command registers (APB side)
`define MAC_HOFS_ADDR     12'h000
`define MAC_HOFS_WDATA    12'h004
`define MAC_HOFS_CMD      12'h008
`define MAC_HOFS_STAT     12'h00C
`define MAC_HOFS_RDATA    12'h010
`define MAC_CMD_GO        0
`define MAC_CMD_WR        1
`define MAC_CMD_BE_LO     4
`define MAC_STAT_BUSY     0

// ==========================================================
// Timing: low word and flag one clock, high word two clocks
`define MAC_LAT_LOW       1
`define MAC_LAT_HIGH      2

`endif

//--- common/mac_pkg.sv
// Types shared by the multiply-accumulate unit and its host end.
// Assumes mac_map.svh is on the include path.
package mac_pkg;
  `include "mac_map.svh"

  typedef enum logic [1:0] {
    MAC_MODE_ADD,
    MAC_MODE_SUB,
    MAC_MODE_RSUB,
    MAC_MODE_RSVD
  } mac_mode_t;

  typedef enum logic [1:0] {
    MAC_PH_IDLE,
    MAC_PH_LOW,
    MAC_PH_HIGH
  } mac_phase_t;

  typedef enum logic [1:0] {
    MAC_HS_IDLE,
    MAC_HS_REQ,
    MAC_HS_DONE
  } mac_hstate_t;

  typedef logic [31:0] mac_word_t;
  typedef logic [3:0]  mac_be_t;
endpackage : mac_pkg

//--- common/mac_if.sv
// Register bus between the CPU-side host end and the unit.
// Single clock; a write completes in the cycle it is presented, read data follows one clock later.
`timescale 1ns/1ps
interface mac_if;
  logic                      req;
  logic                      we;
  logic [15:0]               addr;
  mac_pkg::mac_be_t          be;
  mac_pkg::mac_word_t        wdata;
  mac_pkg::mac_word_t        rdata;

  modport unit (input req, input we, input addr, input be, input wdata, output rdata);
  modport cpu  (output req, output we, output addr, output be, output wdata, input rdata);
endinterface : mac_if

//--- design/mac_arith.sv
// Combinational multiply-accumulate core for one calculation.
// Assumes operands and accumulator are stable in the cycle it is read.
`timescale 1ns/1ps
module mac_arith #(
  parameter int OPW = 32,
  parameter int ACW = 64
) (
  // Operands
  input  wire logic [OPW-1:0] op_a,
  input  wire logic [OPW-1:0] op_b,
  input  wire logic [ACW-1:0] acc,
  // Setup
  input  wire logic [1:0]     mode,
  input  wire logic           sgn,
  // Result
  output logic      [ACW-1:0] res,
  output logic                ovf
);
  import mac_pkg::*;

  logic signed [ACW+1:0] sa;
  logic signed [ACW+1:0] sb;
  logic signed [ACW+1:0] pa;
  logic signed [ACW+1:0] ac;
  logic signed [ACW+1:0] r;
  logic signed [ACW+1:0] umax;
  logic signed [ACW+1:0] smax;
  logic signed [ACW+1:0] smin;

  always_comb begin
    // Widen by two bits so no sum can wrap before range checking
    sa = $signed({{(ACW+2-OPW){op_a[OPW-1]}}, op_a});
    sb = $signed({{(ACW+2-OPW){op_b[OPW-1]}}, op_b});
    if (sgn) begin                                                      // [RULE4]
      // Both factors extended first so the product is formed at full width
      pa = sa * sb;
      ac = $signed({{2{acc[ACW-1]}}, acc});
    end else begin
      pa = $signed({2'b00, (ACW)'(op_a) * (ACW)'(op_b)});               // [RULE5]
      ac = $signed({2'b00, acc});
    end
    case (mac_mode_t'(mode))
      MAC_MODE_ADD:  r = ac + pa;                                       // [RULE1]
      MAC_MODE_SUB:  r = ac - pa;                                       // [RULE2]
      MAC_MODE_RSUB: r = pa - ac;                                       // [RULE3]
      default:       r = ac;                                            // [RULE21]
    endcase
    umax = $signed({2'b00, {ACW{1'b1}}});
    smax = $signed({3'b000, {(ACW-1){1'b1}}});
    smin = -smax - 1;
    res  = r[ACW-1:0];
    if (mac_mode_t'(mode) == MAC_MODE_RSVD) ovf = 1'b0;
    else if (sgn) ovf = (r > smax) || (r < smin);                        // [RULE19]
    else ovf = (r > umax) || (r < 0);                                   // [RULE19]
  end
endmodule : mac_arith

//--- design/mac_unit.sv
// Multiply-accumulate unit: control, operand and accumulator registers.
// Assumes a CPU end that presents one access per cycle on mac_if.
//
// Contract
// RULE1: Mode 00 adds product to accumulator
// RULE2: Mode 01 subtracts product from accumulator
// RULE3: Mode 10 product minus accumulator; 11 reserved
// RULE4: Sign bit selects two's-complement arithmetic
// RULE5: 32-bit operands, 64-bit accumulator
// RULE6: Trigger 000/001/010 on low-byte writes
// RULE7: Trigger 011 acc byte 4; 1xx soft start
// RULE8: Soft start write-only, reads zero
// RULE9: Trigger select and soft start together
// RULE10: Overflow settled two clocks after start
// RULE11: Low word one clock, high two
// RULE12: Each calculation takes one cycle
// RULE13: 32-bit bus, one-clock access
// RULE14: Software writes control whole, no RMW
// RULE15: Long, word, byte access to data
// RULE16: Software writes trigger low byte last
// RULE17: Signed mode uses long-word operand writes
// RULE18: Reset clears all registers
// RULE19: Overflow set on range escape
// RULE20: Overflow sticky; cleared only by writing 0
// RULE21: Reserved mode leaves state unchanged
`timescale 1ns/1ps
module mac_unit #(
  parameter int OPW = 32,
  parameter int ACW = 64
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // Register bus from the CPU end
  mac_if.unit       BUS,
  // Status view
  output logic      OVF,
  output logic      BUSY
);
  import mac_pkg::*;

  typedef struct packed {
    logic [7:0]     ctrl;
    logic [OPW-1:0] opa;
    logic [OPW-1:0] opb;
    logic [ACW-1:0] acc;
    logic [31:0]    res_hi;
    logic           pend;
    mac_phase_t     ph;
    logic           busy;
    logic [31:0]    rdata;
  } mac_state_t;

  // ==========================================================
  // Register selector codes produced by the address decoder
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_OPA  = 3'h1;
  localparam logic [2:0] SEL_OPB  = 3'h2;
  localparam logic [2:0] SEL_ACCL = 3'h3;
  localparam logic [2:0] SEL_ACCH = 3'h4;
  localparam logic [2:0] SEL_CTRL = 3'h5;

  mac_state_t st_ff;
  mac_state_t nxt_st;

  logic [ACW-1:0] a_res;
  logic           a_ovf;
  logic           go;
  logic           wr;
  logic           rd;
  logic [2:0]     sel;
  logic [2:0]     trg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) m[i*8 +: 8] = nw[i*8 +: 8];                            // [RULE15]
    end
    return m;
  endfunction : merge

  // ==========================================================
  // Address decoding, shared by the trigger, write and read paths
  function automatic logic [2:0] reg_sel(input logic [15:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a == `MAC_OFS_OPA) s = SEL_OPA;
    else if (a == `MAC_OFS_OPB) s = SEL_OPB;
    else if (a == `MAC_OFS_ACCL) s = SEL_ACCL;
    else if (a == `MAC_OFS_ACCH) s = SEL_ACCH;
    else if (a == `MAC_OFS_CTRL) s = SEL_CTRL;
    return s;
  endfunction : reg_sel

  // Start request of one write. The select in force before the write decides,
  // except soft start, which may arrive together with its own select.
  function automatic logic trig_hit(input logic [2:0] s, input logic [2:0] tsel,
                                    input logic [3:0] be, input logic [7:0] wd);
    logic h;
    h = 1'b0;
    if (be[0]) begin
      if (s == SEL_OPA) h = (tsel == 3'h0);                             // [RULE6]
      else if (s == SEL_OPB) h = (tsel == 3'h1);                        // [RULE6]
      else if (s == SEL_ACCL) h = (tsel == 3'h2);                       // [RULE6]
      else if (s == SEL_ACCH) h = (tsel == 3'h3);                       // [RULE7]
      else if (s == SEL_CTRL) h = wd[`MAC_CTL_SOFT] && wd[`MAC_CTL_TRG_HI]; // [RULE7][RULE9]
    end
    return h;
  endfunction : trig_hit

  // ==========================================================
  // Arithmetic core
  mac_arith #(.OPW(OPW), .ACW(ACW)) u_arith (
    .op_a (st_ff.opa),
    .op_b (st_ff.opb),
    .acc  (st_ff.acc),
    .mode (st_ff.ctrl[`MAC_CTL_MODE_HI:`MAC_CTL_MODE_LO]),
    .sgn  (st_ff.ctrl[`MAC_CTL_SIGN]),
    .res  (a_res),
    .ovf  (a_ovf)
  );

  // ==========================================================
  // Register access and sequencing
  always_comb begin
    nxt_st = st_ff;
    wr     = BUS.req && BUS.we;
    rd     = BUS.req && !BUS.we;
    sel    = reg_sel(BUS.addr);
    trg    = st_ff.ctrl[`MAC_CTL_TRG_HI:`MAC_CTL_TRG_LO];
    go     = wr && trig_hit(sel, trg, BUS.be, BUS.wdata[7:0]);

    // Bus writes; one cycle per access
    if (wr && sel == SEL_OPA) begin                                     // [RULE13]
      nxt_st.opa = merge(st_ff.opa, BUS.wdata, BUS.be);
    end else if (wr && sel == SEL_OPB) begin
      nxt_st.opb = merge(st_ff.opb, BUS.wdata, BUS.be);
    end else if (wr && sel == SEL_ACCL) begin
      nxt_st.acc[31:0] = merge(st_ff.acc[31:0], BUS.wdata, BUS.be);
    end else if (wr && sel == SEL_ACCH) begin
      nxt_st.acc[63:32] = merge(st_ff.acc[63:32], BUS.wdata, BUS.be);
    end else if (wr && sel == SEL_CTRL && BUS.be[0]) begin
      nxt_st.ctrl = BUS.wdata[7:0];
      nxt_st.ctrl[`MAC_CTL_SOFT] = 1'b0;                                // [RULE8]
      // Writing 1 to the flag does not set it
      nxt_st.ctrl[`MAC_CTL_OVF] = st_ff.ctrl[`MAC_CTL_OVF] & BUS.wdata[`MAC_CTL_OVF]; // [RULE20]
    end

    // Low word lands one clock after start, high word one clock later
    case (st_ff.ph)
      MAC_PH_LOW: begin
        nxt_st.acc[63:32] = st_ff.res_hi;                               // [RULE11]
        nxt_st.ph = MAC_PH_IDLE;
      end
      default: nxt_st.ph = MAC_PH_IDLE;
    endcase

    // Start is held one cycle so the core sees the value just written,
    // and the mode and sign of a soft-start write itself
    nxt_st.pend = go;
    if (st_ff.pend) begin
      // Whole result computed in one cycle; high half staged
      if (st_ff.ctrl[`MAC_CTL_MODE_HI:`MAC_CTL_MODE_LO] != 2'b11) begin // [RULE12][RULE21]
        nxt_st.acc[31:0] = a_res[31:0];                                 // [RULE11]
        nxt_st.res_hi    = a_res[63:32];
        nxt_st.ph        = MAC_PH_LOW;
      end
      // Set wins over a clear in the same cycle
      if (a_ovf) nxt_st.ctrl[`MAC_CTL_OVF] = 1'b1;                      // [RULE10][RULE20]
    end

    // Busy covers the held start and the pending high word
    nxt_st.busy = nxt_st.pend || (nxt_st.ph != MAC_PH_IDLE);

    // ==========================================================
    // Read data, registered; zero on any cycle without a read
    nxt_st.rdata = 32'h0000_0000;
    if (rd) begin
      if (sel == SEL_OPA) nxt_st.rdata = st_ff.opa;
      else if (sel == SEL_OPB) nxt_st.rdata = st_ff.opb;
      else if (sel == SEL_ACCL) nxt_st.rdata = st_ff.acc[31:0];
      else if (sel == SEL_ACCH) nxt_st.rdata = st_ff.acc[63:32];
      else if (sel == SEL_CTRL) nxt_st.rdata = {24'h00_0000, st_ff.ctrl};
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff.ctrl   <= `MAC_RST_CTRL;                                    // [RULE18]
      st_ff.opa    <= `MAC_RST_DATA;
      st_ff.opb    <= `MAC_RST_DATA;
      st_ff.acc    <= {`MAC_RST_DATA, `MAC_RST_DATA};
      st_ff.res_hi <= `MAC_RST_DATA;
      st_ff.pend   <= 1'b0;
      st_ff.ph     <= MAC_PH_IDLE;
      st_ff.busy   <= 1'b0;
      st_ff.rdata  <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign BUS.rdata = st_ff.rdata;
  assign OVF       = st_ff.ctrl[`MAC_CTL_OVF];
  assign BUSY      = st_ff.busy;
endmodule : mac_unit

//--- design/mac_host.sv
// CPU end: an APB slave whose command registers drive one access on mac_if.
// Assumes the unit returns read data one clock after the access.
`timescale 1ns/1ps
module mac_host (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Register bus to the unit
  mac_if.cpu               BUS
);
  import mac_pkg::*;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        we;
    logic [3:0]  be;
    logic [31:0] rdata;
    mac_hstate_t hs;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mac_hst_t;

  mac_hst_t st_ff;
  mac_hst_t nxt_st;
  logic     acc_ph;
  logic     wr_ph;

  // ==========================================================
  // Command registers and access sequencing
  always_comb begin
    nxt_st = st_ff;
    acc_ph = PSEL && PENABLE && !st_ff.pready;
    // A write lands only at the edge that completes the transfer
    wr_ph  = PSEL && PENABLE && st_ff.pready && PWRITE;
    nxt_st.pready  = acc_ph;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata  = 32'h0000_0000;
    case (st_ff.hs)
      MAC_HS_REQ:  nxt_st.hs = MAC_HS_DONE;
      MAC_HS_DONE: begin
        nxt_st.rdata = BUS.rdata;
        nxt_st.hs    = MAC_HS_IDLE;
      end
      default:     nxt_st.hs = MAC_HS_IDLE;
    endcase
    if (PSEL && PENABLE) begin
      if (PADDR == `MAC_HOFS_ADDR) begin
        if (wr_ph) nxt_st.addr = PWDATA[15:0];
        nxt_st.prdata = {16'h0000, st_ff.addr};
      end else if (PADDR == `MAC_HOFS_WDATA) begin
        if (wr_ph) nxt_st.wdata = PWDATA;
        nxt_st.prdata = st_ff.wdata;
      end else if (PADDR == `MAC_HOFS_CMD) begin
        // Control register is always written whole, never read-modified
        if (wr_ph && PWDATA[`MAC_CMD_GO] && st_ff.hs == MAC_HS_IDLE) begin // [RULE14]
          nxt_st.we = PWDATA[`MAC_CMD_WR];
          nxt_st.be = PWDATA[`MAC_CMD_BE_LO +: 4];
          nxt_st.hs = MAC_HS_REQ;
        end
        nxt_st.prdata = {24'h00_0000, st_ff.be, 2'b00, st_ff.we, 1'b0};
      end else if (PADDR == `MAC_HOFS_STAT) begin
        nxt_st.prdata = {31'h0000_0000, st_ff.hs != MAC_HS_IDLE};
      end else if (PADDR == `MAC_HOFS_RDATA) begin
        nxt_st.prdata = st_ff.rdata;
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end
    // Answer fields stand only with the ready pulse
    if (!acc_ph) begin
      nxt_st.prdata  = 32'h0000_0000;
      nxt_st.pslverr = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff <= '{addr: 16'h0000, wdata: 32'h0000_0000, we: 1'b0, be: 4'h0,
                 rdata: 32'h0000_0000, hs: MAC_HS_IDLE, prdata: 32'h0000_0000,
                 pready: 1'b0, pslverr: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign BUS.req   = (st_ff.hs == MAC_HS_REQ);
  assign BUS.we    = st_ff.we;
  assign BUS.addr  = st_ff.addr;
  assign BUS.be    = st_ff.be;
  assign BUS.wdata = st_ff.wdata;
  assign PRDATA    = st_ff.prdata;
  assign PREADY    = st_ff.pready;
  assign PSLVERR   = st_ff.pslverr;
endmodule : mac_host

//--- bench/mac_sva.sv
// Checker on the bus joining the host end and the unit, and on the status outputs.
// Assumes it sits beside the mac_if instance that joins the two ends.
`timescale 1ns/1ps
`include "mac_map.svh"
module mac_sva (
  // Clock and reset
  input wire logic               CLK,
  input wire logic               RST,
  // Bus and status
  input wire logic               req,
  input wire logic               we,
  input wire logic [15:0]        addr,
  input wire mac_pkg::mac_be_t   be,
  input wire mac_pkg::mac_word_t wdata,
  input wire mac_pkg::mac_word_t rdata,
  input wire logic               OVF,
  input wire logic               BUSY
);
  import mac_pkg::*;
  logic wr;
  logic cw;
  assign wr = req && we;
  assign cw = wr && addr == `MAC_OFS_CTRL && be[0];
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ==========================================
  // Assertions
  a_soft_reads_zero: assert property (
    req && !we && addr == `MAC_OFS_CTRL |=> !rdata[6]) else $error("soft start read as one");
  a_unmapped_zero: assert property (
    req && !we && addr == 16'h1BF0 |=> rdata == 32'h0000_0000) else $error("hole read not zero");
  a_reset_clear: assert property (
    $fell(RST) |-> !OVF && !BUSY) else $error("status set after reset");
  a_soft_start_busy: assert property (
    cw && wdata[6] && wdata[5] |-> ##[1:2] BUSY) else $error("soft start did not start");
  a_busy_from_write: assert property (
    $rose(BUSY) |-> $past(wr) || $past(wr, 2)) else $error("busy without a write");
  a_ovf_after_start: assert property (
    $rose(OVF) |-> BUSY || $past(BUSY)) else $error("overflow rose outside a calculation");
  a_ovf_sticky: assert property (
    OVF && !cw |=> OVF) else $error("overflow dropped without a write");
  a_ovf_clear: assert property (
    cw && !wdata[7] && !wdata[6] && !BUSY && !$past(wr) |=> !OVF)
    else $error("overflow not cleared");
  c_soft: cover property (cw && wdata[6]);
  c_ovf: cover property ($rose(OVF));
  c_high: cover property (req && !we && addr == `MAC_OFS_ACCH);
endmodule : mac_sva

//--- bench/multiply_accumulate_unit_tb.sv
// Self-checking bench: APB master on the host end, integer model of the unit.
// Assumes the host and unit face each other across one mac_if.
`timescale 1ns/1ps
`include "mac_map.svh"
module multiply_accumulate_unit_tb;
  import mac_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        pready;
  logic        pslverr;
  logic        e;
  logic        ovf;
  logic        busy;
  logic [63:0] acc;
  logic [31:0] opa;
  logic [31:0] opb;
  logic        ovf_m;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [15:0] regs [5] = '{`MAC_OFS_OPA, `MAC_OFS_OPB, `MAC_OFS_ACCL, `MAC_OFS_ACCH,
                            `MAC_OFS_CTRL};
  mac_if bus ();
  mac_host u_mac_host (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BUS(bus));
  mac_unit u_mac_unit (.CLK(clk), .RST(rst), .BUS(bus), .OVF(ovf), .BUSY(busy));
  mac_sva u_mac_sva (.CLK(clk), .RST(rst), .req(bus.req), .we(bus.we), .addr(bus.addr),
    .be(bus.be), .wdata(bus.wdata), .rdata(bus.rdata), .OVF(ovf), .BUSY(busy));
  // ==========================================
  // Tasks
  task automatic stop_test();
    $display("Mismatches %0d, comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(string n, logic [63:0] x, logic [63:0] s);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic tmo(int n);
    if (n >= 20) begin
      miscompares++;
      stop_test();
    end
  endtask : tmo
  // Idle cycle after each transfer keeps one assignment per time step
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    tmo(n);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic op(logic w, logic [15:0] a, logic [31:0] d, logic [3:0] be);
    int n;
    n = 0;
    apb(1'b1, 12'h000, {16'h0000, a});
    apb(1'b1, 12'h004, d);
    apb(1'b1, 12'h008, {24'h00_0000, be, 2'h0, w, 1'b1});
    do begin
      apb(1'b0, 12'h00C, 32'h0000_0000);
      n++;
    end while (r[0] !== 1'b0 && n < 20);
    tmo(n);
    if (!w) apb(1'b0, 12'h010, 32'h0000_0000);
  endtask : op
  task automatic model(logic [1:0] m, logic s);
    logic signed [65:0] pa, pb, x, y;
    pa = s ? {{34{opa[31]}}, opa} : {34'h0, opa};
    pb = s ? {{34{opb[31]}}, opb} : {34'h0, opb};
    x = s ? {{2{acc[63]}}, acc} : {2'h0, acc};
    y = m == 2'h0 ? x + pa * pb : m == 2'h1 ? x - pa * pb : pa * pb - x;
    if (m != 2'h3) begin
      acc = y[63:0];
      if (s ? (y[65:63] != 3'h0 && y[65:63] != 3'h7) : y[65:64] != 2'h0) ovf_m = 1'b1;
    end
  endtask : model
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    logic [2:0]  t;
    logic [7:0]  c;
    logic [31:0] td [4];
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ovf_m = 1'b0;
    void'($urandom(32'h8ef2c5c1));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[k]) begin
      op(1'b0, regs[k], 32'h0000_0000, 4'hF);
      chk("reset value", 64'h0, {32'h0, r});
    end
    op(1'b0, 16'h1BF0, 32'h0000_0000, 4'hF);
    chk("hole read", 64'h0, {32'h0, r});
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("apb error", 64'h1, {63'h0, e});
    for (int i = 0; i < 30; i++) begin
      t = (i % 5 == 4) ? 3'($urandom_range(7, 4)) : 3'(i % 5);
      opa = $urandom;
      opb = $urandom;
      acc = {$urandom, $urandom};
      if (i % 6 == 5) ovf_m = 1'b0;
      c = {ovf_m, 1'b0, 3'h4, 1'((i / 4) % 2), 2'(i % 4)};
      op(1'b1, `MAC_OFS_CTRL, {24'h00_0000, c}, 4'h1);
      op(1'b1, `MAC_OFS_ACCL, acc[31:0], 4'hF);
      op(1'b1, `MAC_OFS_ACCH, acc[63:32], 4'hF);
      op(1'b1, `MAC_OFS_OPA, opa, 4'hF);
      // Unsigned runs load the second operand in halves, low half last
      op(1'b1, `MAC_OFS_OPB, opb, c[2] ? 4'hF : 4'hC);
      if (!c[2]) op(1'b1, `MAC_OFS_OPB, opb, 4'h3);
      c[5:3] = t;
      c[6] = t[2];
      op(1'b1, `MAC_OFS_CTRL, {24'h00_0000, c}, 4'h1);
      td = '{opa, opb, acc[31:0], acc[63:32]};
      // Signed runs keep to long-word writes, also for the trigger write
      if (!t[2]) op(1'b1, regs[t[1:0]], td[t[1:0]], c[2] ? 4'hF : 4'h1);
      model(c[1:0], c[2]);
      op(1'b0, `MAC_OFS_ACCL, 32'h0000_0000, 4'hF);
      chk("acc low", {32'h0, acc[31:0]}, {32'h0, r});
      op(1'b0, `MAC_OFS_ACCH, 32'h0000_0000, 4'hF);
      chk("acc high", {32'h0, acc[63:32]}, {32'h0, r});
      op(1'b0, `MAC_OFS_CTRL, 32'h0000_0000, 4'hF);
      chk("control", {56'h0, ovf_m, 1'b0, c[5:0]}, {32'h0, r});
      chk("ovf pin", {63'h0, ovf_m}, {63'h0, ovf});
    end
    stop_test();
  end
endmodule : multiply_accumulate_unit_tb
